// [testbench/adc_seq_asserts.sv]
// port checker for the sequencer: bus, converter link, path pins
// assumes binding to the top module, no software writes to control
// while a run is busy (the design refuses such writes, but the copy here would still take them)
`default_nettype none
module adc_seq_asserts #(
	parameter int fifo_depth = 16,
	parameter int fifo_addr_w = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic conv_start,
	input wire logic conv_done,
	input wire logic [adc_seq_pkg::chan_w-1:0] conv_channel,
	input wire logic [3:0] ext_select,
	input wire logic [3:0] int_select,
	input wire logic [3:0] buffer_route_switch,
	input wire logic buffer_path_en,
	input wire logic buffer_amp_en,
	input wire logic [3:0] input_enable,
	input wire logic [adc_seq_pkg::div_w-1:0] divider_select,
	input wire logic div3_active,
	input wire logic rail_to_rail_en
);
	timeunit 1ns;
	timeprecision 1ns;
	logic cont_reg;
	logic seen_reg;
	logic [15:0] delay_reg;
	logic [16:0] gap_reg;
	logic [16:0] exp_gap;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	assign exp_gap = cont_reg ? 17'(delay_reg) + 17'h2 : 17'h1;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cont_reg <= 1'b0;
			delay_reg <= 16'h0;
		end
		else if (wr && addr == adc_seq_pkg::sequencer_control_off)
			cont_reg <= wdata[adc_seq_pkg::ctl_cont_bit];
		else if (wr && addr == adc_seq_pkg::delay_off)
			delay_reg <= wdata[15:0];
	end
	// gap since last result; a late start simply ends the watch
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			gap_reg <= 17'h0;
			seen_reg <= 1'b0;
		end
		else if (conv_done)
		begin
			gap_reg <= 17'h1;
			seen_reg <= 1'b1;
		end
		else
		begin
			gap_reg <= gap_reg + 17'h1;
			if (gap_reg >= exp_gap)
				seen_reg <= 1'b0;
		end
	end
	function automatic logic [3:0] int_of(input logic [4:0] c);
		case (c)
			adc_seq_pkg::chan_vdda_half: return 4'h1;
			adc_seq_pkg::chan_vcore: return 4'h2;
			adc_seq_pkg::chan_vssa: return 4'h4;
			adc_seq_pkg::chan_vddio_quarter: return 4'h8;
			default: return 4'h0;
		endcase
	endfunction : int_of
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_start_pulse: assert property (conv_start |=> !conv_start)
		else $error("conv_start longer than one cycle");
	a_seq_gap: assert property (conv_start && seen_reg |->
		gap_reg == exp_gap)
		else $error("start spacing after result wrong");
	a_rdata_quiet: assert property (!$past(rd) |-> rdata == 32'h0)
		else $error("read data outside read slot");
	a_div3_level: assert property (div3_active ==
		(buffer_path_en && divider_select == adc_seq_pkg::div_by_three))
		else $error("divide by three flag wrong");
	a_input_gate: assert property
		((ext_select & ~input_enable & ~$past(input_enable)) == 4'h0)
		else $error("disabled input selected");
	a_ext_map: assert property (ext_select != 4'h0 |->
		conv_channel <= adc_seq_pkg::chan_ext_last &&
		ext_select == 4'h1 << conv_channel[1:0])
		else $error("external select does not match channel");
	a_int_map: assert property (int_select != 4'h0 |->
		int_select == int_of(conv_channel))
		else $error("internal select does not match channel");
	a_path_write: assert property (wr && addr ==
		adc_seq_pkg::analog_path_config_off |=> ($past(wdata) & 32'h1fff) ==
		{19'h0, rail_to_rail_en, divider_select, buffer_amp_en,
		buffer_path_en, input_enable, buffer_route_switch})
		else $error("path pins differ from written config");
endmodule : adc_seq_asserts
`default_nettype wire

// [testbench/adc_sequencer_input_path_tb.sv]
// bench: register traffic, single, triggered and continuous runs
// assumes core model answers every start within six cycles
`default_nettype none
module adc_sequencer_input_path_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst, wr, rd, hw_trigger, conv_start, conv_done;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic [11:0] conv_data;
	logic [4:0] conv_channel;
	logic [3:0] ext_select, int_select, buffer_route_switch, input_enable;
	logic buffer_path_en, buffer_amp_en, div3_active, rail_to_rail_en;
	logic fifo_threshold_irq, rd_d;
	logic [1:0] divider_select;
	logic [6:0] salt;
	logic [2:0] lat;
	logic [12:0] v;
	logic [6:0] s_run [4];
	logic [31:0] exp_q [$];
	logic [31:0] msk_q [$];
	logic [4:0] ids [8] = '{5'h0, 5'h1, 5'h2, 5'h3, 5'h0c, 5'h0e, 5'h0f, 5'h12};
	int n_mismatch, cmp_count, done_cnt, cyc;
	adc_sequencer_input_path u_dut (.clk(clk), .rst(rst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.hw_trigger(hw_trigger), .conv_start(conv_start),
		.conv_done(conv_done), .conv_data(conv_data),
		.conv_channel(conv_channel), .ext_select(ext_select),
		.int_select(int_select), .buffer_route_switch(buffer_route_switch),
		.buffer_path_en(buffer_path_en), .buffer_amp_en(buffer_amp_en),
		.input_enable(input_enable), .divider_select(divider_select),
		.div3_active(div3_active), .rail_to_rail_en(rail_to_rail_en),
		.fifo_threshold_irq(fifo_threshold_irq));
	conv_core_model u_core (.clk(clk), .rst(rst), .conv_start(conv_start),
		.conv_channel(conv_channel), .lat(lat), .salt(salt),
		.conv_done(conv_done), .conv_data(conv_data));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic stop_test;
		if (n_mismatch == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back(e);
		msk_q.push_back(m);
		@(posedge clk);
		rd <= 1'b0;
	endtask : rd_reg
	task automatic wait_done(input int n);
		int t;
		t = done_cnt + n;
		while (done_cnt < t)
			@(posedge clk);
		repeat (3) @(posedge clk);
	endtask : wait_done
	task automatic run(input int r, input bit hw);
		s_run[r] = 7'($urandom);
		salt <= s_run[r];
		if (hw)
		begin
			// start command only arms; the pin edge launches the run
			wr_reg(adc_seq_pkg::command_off, 32'h1);
			@(posedge clk);
			hw_trigger <= 1'b1;
			repeat (3) @(posedge clk);
			hw_trigger <= 1'b0;
		end
		else
		begin
			wr_reg(adc_seq_pkg::command_off, 32'h1);
			// refused: the run must keep the old slot ids
			wr_reg(adc_seq_pkg::slot_channel_select_low_off, 32'h0);
		end
		wait_done(8);
	endtask : run
	task automatic rd_fifo(input int r);
		for (int k = 0; k < 8; k++)
			rd_reg(adc_seq_pkg::fifo_data_off,
				{15'h0, ids[k], s_run[r], ids[k]}, '1);
	endtask : rd_fifo
	// ------------------------------------------------------------
	// clock, watchers
	// ------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (conv_done)
			done_cnt++;
		if (conv_start)
			lat <= 3'($urandom_range(6, 1));
		if (rd_d)
			chk("rdata", exp_q.pop_front(), rdata & msk_q.pop_front());
		rd_d <= rd;
		if (cyc == 20000)
		begin
			n_mismatch++;
			stop_test();
		end
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		rst = 1'b1;
		{addr, wdata, wr, rd, hw_trigger, salt, rd_d} = '0;
		lat = 3'h2;
		{n_mismatch, cmp_count, done_cnt, cyc} = '0;
		void'($urandom(14));
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd_reg(adc_seq_pkg::status_off, 32'h0, '1);
		rd_reg(adc_seq_pkg::threshold_off, 32'h8, '1);
		rd_reg(8'h3c, 32'h0, '1);
		rd_reg(adc_seq_pkg::fifo_data_off, 32'h0, '1);
		for (int i = 0; i < 4; i++)
		begin
			v = 13'($urandom);
			v[11:10] = 2'(i);
			wr_reg(adc_seq_pkg::analog_path_config_off, 32'(v));
			// pins update at the write edge; look once they settle
			@(negedge clk);
			chk("path", 32'(v), 32'({rail_to_rail_en, divider_select,
				buffer_amp_en, buffer_path_en, input_enable,
				buffer_route_switch}));
			chk("div3", 32'(v[8] && i == 3), 32'(div3_active));
			rd_reg(adc_seq_pkg::analog_path_config_off, 32'(v), '1);
		end
		// unbuffered, divider zero, input three held off
		wr_reg(adc_seq_pkg::analog_path_config_off, 32'h70);
		// internal reference assumed, so input zero may sit in a slot
		wr_reg(adc_seq_pkg::slot_channel_select_low_off, 32'h03020100);
		wr_reg(adc_seq_pkg::slot_channel_select_high_off, 32'h120f0e0c);
		wr_reg(adc_seq_pkg::sequencer_control_off, 32'h70);
		run(0, 1'b0);
		chk("irq", 32'h1, 32'(fifo_threshold_irq));
		rd_reg(adc_seq_pkg::status_off, 32'h208, '1);
		rd_fifo(0);
		rd_reg(adc_seq_pkg::status_off, 32'h0, '1);
		chk("irq", 32'h0, 32'(fifo_threshold_irq));
		wr_reg(adc_seq_pkg::sequencer_control_off, 32'h72);
		for (int r = 1; r < 4; r++)
			run(r, 1'b1);
		rd_reg(adc_seq_pkg::status_off, 32'h610, '1);
		rd_fifo(2);
		rd_fifo(3);
		wr_reg(adc_seq_pkg::status_off, 32'h400);
		rd_reg(adc_seq_pkg::status_off, 32'h0, '1);
		// unbuffered path, so only the faster rate limit applies
		wr_reg(adc_seq_pkg::delay_off, 32'($urandom_range(20, 3)));
		wr_reg(adc_seq_pkg::sequencer_control_off, 32'h11);
		wr_reg(adc_seq_pkg::command_off, 32'h1);
		wait_done(6);
		rd_reg(adc_seq_pkg::status_off, 32'h100, 32'h100);
		wr_reg(adc_seq_pkg::command_off, 32'h2);
		repeat (60) @(posedge clk);
		rd_reg(adc_seq_pkg::status_off, 32'h0, 32'h100);
		repeat (2) @(posedge clk);
		stop_test();
	end
endmodule : adc_sequencer_input_path_tb
bind adc_sequencer_input_path adc_seq_asserts #(.fifo_depth(fifo_depth),
	.fifo_addr_w(fifo_addr_w)) u_chk (.clk(clk), .rst(rst), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.conv_start(conv_start), .conv_done(conv_done),
	.conv_channel(conv_channel), .ext_select(ext_select),
	.int_select(int_select), .buffer_route_switch(buffer_route_switch),
	.buffer_path_en(buffer_path_en), .buffer_amp_en(buffer_amp_en),
	.input_enable(input_enable), .divider_select(divider_select),
	.div3_active(div3_active), .rail_to_rail_en(rail_to_rail_en));
`default_nettype wire

// [testbench/conv_core_model.sv]
// converter core stand-in: one result per start after lat cycles
// assumes conv_channel stands until the result is handed back
`default_nettype none
module conv_core_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic conv_start,
	input wire logic [adc_seq_pkg::chan_w-1:0] conv_channel,
	input wire logic [2:0] lat,
	input wire logic [6:0] salt,
	output logic conv_done,
	output logic [11:0] conv_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] cnt_reg;
	// ------------------------------------------------------------
	// conversion
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_reg <= 3'h0;
			conv_done <= 1'b0;
			conv_data <= 12'h5a5;
		end
		else
		begin
			conv_done <= 1'b0;
			// toggles off the result cycle so stale data never matches
			conv_data <= ~conv_data;
			if (conv_start)
				cnt_reg <= lat;
			else if (cnt_reg == 3'h1)
			begin
				cnt_reg <= 3'h0;
				conv_done <= 1'b1;
				conv_data <= {salt, conv_channel};
			end
			else if (cnt_reg != 3'h0)
				cnt_reg <= cnt_reg - 3'h1;
		end
	end
endmodule : conv_core_model
`default_nettype wire

// [verilog/adc_seq_pkg.sv]
// register map, field layout and encodings of the sequencer
// assumes a 32-bit register port with word-aligned byte offsets
`default_nettype none
package adc_seq_pkg;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] sequencer_control_off = 8'h00;
	localparam logic [7:0] command_off = 8'h04;
	localparam logic [7:0] delay_off = 8'h08;
	localparam logic [7:0] slot_channel_select_low_off = 8'h0c;
	localparam logic [7:0] slot_channel_select_high_off = 8'h10;
	localparam logic [7:0] analog_path_config_off = 8'h14;
	localparam logic [7:0] fifo_data_off = 8'h18;
	localparam logic [7:0] status_off = 8'h1c;
	localparam logic [7:0] threshold_off = 8'h20;
	// ------------------------------------------------------------
	// fields
	// ------------------------------------------------------------
	localparam int ctl_cont_bit = 0;
	localparam int ctl_hw_bit = 1;
	localparam int ctl_slots_lsb = 4;
	localparam int cmd_start_bit = 0;
	localparam int cmd_stop_bit = 1;
	localparam int slot_field_stride = 8;
	localparam int apc_route_lsb = 0;
	localparam int apc_inen_lsb = 4;
	localparam int apc_path_bit = 8;
	localparam int apc_amp_bit = 9;
	localparam int apc_div_lsb = 10;
	localparam int apc_rail_bit = 12;
	localparam int fifo_chan_lsb = 16;
	localparam int st_busy_bit = 8;
	localparam int st_thr_bit = 9;
	localparam int st_ovr_bit = 10;
	localparam int result_w = 12;
	localparam int chan_w = 5;
	localparam int slot_idx_w = 3;
	localparam int delay_w = 16;
	localparam int div_w = 2;
	localparam int ext_inputs = 4;
	// ------------------------------------------------------------
	// channel identifiers and reset values
	// ------------------------------------------------------------
	localparam logic [4:0] chan_ext_last = 5'h03;
	localparam logic [4:0] chan_vdda_half = 5'h0c;
	localparam logic [4:0] chan_vcore = 5'h0e;
	localparam logic [4:0] chan_vssa = 5'h0f;
	localparam logic [4:0] chan_vddio_quarter = 5'h12;
	localparam logic [1:0] div_by_three = 2'h3;
	localparam logic [4:0] threshold_rst = 5'h08;
	typedef enum {st_idle, st_wait_trig, st_start, st_busy, st_delay}
		seq_state_t;
endpackage : adc_seq_pkg
`default_nettype wire

// [verilog/adc_sequencer_input_path.sv]
// sequencer, result fifo and analog input path controls
// assumes the converter core and hardware trigger pin sit outside
`default_nettype none
module adc_sequencer_input_path #(
	parameter int fifo_depth = 16,
	parameter int fifo_addr_w = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic hw_trigger,
	output logic conv_start,
	input wire logic conv_done,
	input wire logic [adc_seq_pkg::result_w-1:0] conv_data,
	output logic [adc_seq_pkg::chan_w-1:0] conv_channel,
	output logic [3:0] ext_select,
	output logic [3:0] int_select,
	output logic [3:0] buffer_route_switch,
	output logic buffer_path_en,
	output logic buffer_amp_en,
	output logic [3:0] input_enable,
	output logic [adc_seq_pkg::div_w-1:0] divider_select,
	output logic div3_active,
	output logic rail_to_rail_en,
	output logic fifo_threshold_irq
);
	localparam int entry_w = adc_seq_pkg::result_w + adc_seq_pkg::chan_w;
	localparam int slot_n = 8;
	localparam int cnt_w = fifo_addr_w + 1;

	// ------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------
	logic cont_reg;
	logic hw_mode_reg;
	logic [adc_seq_pkg::slot_idx_w-1:0] last_slot_reg;
	logic [adc_seq_pkg::delay_w-1:0] delay_reg;
	logic [adc_seq_pkg::chan_w-1:0] slot_chan_reg [slot_n];
	logic [3:0] route_reg;
	logic [3:0] inen_reg;
	logic path_reg;
	logic amp_reg;
	logic [adc_seq_pkg::div_w-1:0] div_reg;
	logic rail_reg;
	logic [cnt_w-1:0] thr_reg;
	logic ovr_reg;

	logic wr_ctl, wr_cmd, wr_slot_lo, wr_slot_hi, wr_apc, wr_thr, wr_st;
	logic start_cmd, stop_cmd, busy;
	adc_seq_pkg::seq_state_t state_reg;

	assign wr_ctl = wr && addr == adc_seq_pkg::sequencer_control_off;
	assign wr_cmd = wr && addr == adc_seq_pkg::command_off;
	assign wr_slot_lo = wr && addr == adc_seq_pkg::slot_channel_select_low_off;
	assign wr_slot_hi = wr &&
		addr == adc_seq_pkg::slot_channel_select_high_off;
	assign wr_apc = wr && addr == adc_seq_pkg::analog_path_config_off;
	assign wr_thr = wr && addr == adc_seq_pkg::threshold_off;
	assign wr_st = wr && addr == adc_seq_pkg::status_off;
	assign start_cmd = wr_cmd && wdata[adc_seq_pkg::cmd_start_bit];
	assign stop_cmd = wr_cmd && wdata[adc_seq_pkg::cmd_stop_bit];
	assign busy = state_reg != adc_seq_pkg::st_idle;

	// mode and slot count stay fixed while a sequence runs
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cont_reg <= 1'b0;
			hw_mode_reg <= 1'b0;
			last_slot_reg <= '0;
			delay_reg <= '0;
		end
		else if (wr_ctl && !busy)
		begin
			cont_reg <= wdata[adc_seq_pkg::ctl_cont_bit];
			hw_mode_reg <= wdata[adc_seq_pkg::ctl_hw_bit];
			last_slot_reg <= wdata[adc_seq_pkg::ctl_slots_lsb +:
				adc_seq_pkg::slot_idx_w];
		end
		else if (wr && addr == adc_seq_pkg::delay_off)
		begin
			delay_reg <= wdata[adc_seq_pkg::delay_w-1:0];
		end
	end

	// slot ids ignore writes during a run so the sequence stays coherent
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < slot_n; i++)
			begin
				slot_chan_reg[i] <= '0;
			end
		end
		else if (!busy)
		begin
			for (int i = 0; i < slot_n / 2; i++)
			begin
				if (wr_slot_lo)
				begin
					slot_chan_reg[i] <= wdata[i *
						adc_seq_pkg::slot_field_stride +:
						adc_seq_pkg::chan_w];
				end
				if (wr_slot_hi)
				begin
					slot_chan_reg[i + slot_n / 2] <= wdata[i *
						adc_seq_pkg::slot_field_stride +:
						adc_seq_pkg::chan_w];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// analog input path controls
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			route_reg <= '0;
			inen_reg <= '0;
			path_reg <= 1'b0;
			amp_reg <= 1'b0;
			div_reg <= '0;
			rail_reg <= 1'b0;
		end
		else if (wr_apc)
		begin
			route_reg <= wdata[adc_seq_pkg::apc_route_lsb +:
				adc_seq_pkg::ext_inputs];
			inen_reg <= wdata[adc_seq_pkg::apc_inen_lsb +:
				adc_seq_pkg::ext_inputs];
			path_reg <= wdata[adc_seq_pkg::apc_path_bit];
			amp_reg <= wdata[adc_seq_pkg::apc_amp_bit];
			div_reg <= wdata[adc_seq_pkg::apc_div_lsb +:
				adc_seq_pkg::div_w];
			rail_reg <= wdata[adc_seq_pkg::apc_rail_bit];
		end
	end

	assign buffer_route_switch = route_reg;
	assign buffer_path_en = path_reg;
	assign buffer_amp_en = amp_reg;
	assign input_enable = inen_reg;
	// divider only matters on the buffered path; zero is software's job
	assign divider_select = div_reg;
	assign div3_active = path_reg &&
		div_reg == adc_seq_pkg::div_by_three;
	assign rail_to_rail_en = rail_reg;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			thr_reg <= adc_seq_pkg::threshold_rst;
		end
		else if (wr_thr)
		begin
			thr_reg <= wdata[cnt_w-1:0];
		end
	end

	// ------------------------------------------------------------
	// hardware trigger synchroniser
	// ------------------------------------------------------------
	logic [2:0] trig_sync_reg;
	logic trig_level_reg;
	logic trig_event;

	// only stages two and three feed the filter
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			trig_sync_reg <= '0;
			trig_level_reg <= 1'b0;
		end
		else
		begin
			trig_sync_reg <= {trig_sync_reg[1:0], hw_trigger};
			if (trig_sync_reg[1] == trig_sync_reg[2])
			begin
				trig_level_reg <= trig_sync_reg[2];
			end
		end
	end

	assign trig_event = !trig_level_reg && trig_sync_reg[1] &&
		trig_sync_reg[2];

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	logic [adc_seq_pkg::slot_idx_w-1:0] slot_reg;
	logic [adc_seq_pkg::delay_w-1:0] wait_reg;
	logic last_slot;
	logic push;

	assign last_slot = slot_reg == last_slot_reg;
	assign push = state_reg == adc_seq_pkg::st_busy && conv_done;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= adc_seq_pkg::st_idle;
			slot_reg <= '0;
			wait_reg <= '0;
		end
		else if (stop_cmd)
		begin
			state_reg <= adc_seq_pkg::st_idle;
		end
		else
		begin
			unique case (state_reg)
				adc_seq_pkg::st_idle:
				begin
					slot_reg <= '0;
					if (start_cmd)
					begin
						state_reg <= hw_mode_reg ?
							adc_seq_pkg::st_wait_trig :
							adc_seq_pkg::st_start;
					end
				end
				adc_seq_pkg::st_wait_trig:
				begin
					if (trig_event)
					begin
						state_reg <= adc_seq_pkg::st_start;
					end
				end
				adc_seq_pkg::st_start:
				begin
					state_reg <= adc_seq_pkg::st_busy;
				end
				adc_seq_pkg::st_busy:
				begin
					if (conv_done)
					begin
						slot_reg <= last_slot ? '0 :
							slot_reg + 1'b1;
						wait_reg <= delay_reg;
						if (last_slot && !cont_reg)
						begin
							state_reg <= adc_seq_pkg::st_idle;
						end
						else if (cont_reg)
						begin
							state_reg <= adc_seq_pkg::st_delay;
						end
						else
						begin
							state_reg <= adc_seq_pkg::st_start;
						end
					end
				end
				adc_seq_pkg::st_delay:
				begin
					// a zero delay still costs one cycle here
					if (wait_reg == '0)
					begin
						state_reg <= adc_seq_pkg::st_start;
					end
					else
					begin
						wait_reg <= wait_reg - 1'b1;
					end
				end
			endcase
		end
	end

	assign conv_start = state_reg == adc_seq_pkg::st_start;

	// ------------------------------------------------------------
	// channel decode
	// ------------------------------------------------------------
	logic [adc_seq_pkg::chan_w-1:0] chan_reg;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			chan_reg <= '0;
			ext_select <= '0;
			int_select <= '0;
		end
		else
		begin
			chan_reg <= slot_chan_reg[slot_reg];
			for (int i = 0; i < adc_seq_pkg::ext_inputs; i++)
			begin
				ext_select[i] <= busy && inen_reg[i] &&
					slot_chan_reg[slot_reg] ==
					adc_seq_pkg::chan_w'(i);
			end
			int_select[0] <= busy && slot_chan_reg[slot_reg] ==
				adc_seq_pkg::chan_vdda_half;
			int_select[1] <= busy && slot_chan_reg[slot_reg] ==
				adc_seq_pkg::chan_vcore;
			int_select[2] <= busy && slot_chan_reg[slot_reg] ==
				adc_seq_pkg::chan_vssa;
			int_select[3] <= busy && slot_chan_reg[slot_reg] ==
				adc_seq_pkg::chan_vddio_quarter;
		end
	end

	// reserved ids select nothing; input zero vs external ref is software's
	assign conv_channel = chan_reg;

	// ------------------------------------------------------------
	// result fifo
	// ------------------------------------------------------------
	logic [fifo_addr_w-1:0] wr_ptr_reg, rd_ptr_reg;
	logic [cnt_w-1:0] count_reg;
	logic pop, full, drop_old;
	logic [entry_w-1:0] mem_q;

	assign pop = rd && addr == adc_seq_pkg::fifo_data_off &&
		count_reg != '0;
	assign full = count_reg == cnt_w'(fifo_depth);
	assign drop_old = push && full && !pop;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (push)
			begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop || drop_old)
			begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			if (push && !pop && !full)
			begin
				count_reg <= count_reg + 1'b1;
			end
			else if (pop && !push)
			begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

	// overrun is sticky; a new overrun beats a clear in the same cycle
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ovr_reg <= 1'b0;
		end
		else if (drop_old)
		begin
			ovr_reg <= 1'b1;
		end
		else if (wr_st && wdata[adc_seq_pkg::st_ovr_bit])
		begin
			ovr_reg <= 1'b0;
		end
	end

	assign fifo_threshold_irq = count_reg >= thr_reg;

	result_fifo_mem #(
		.width(entry_w),
		.depth(fifo_depth),
		.addr_w(fifo_addr_w)
	) u_mem (
		.clk(clk),
		.wr_en(push),
		.wr_addr(wr_ptr_reg),
		.wr_data({chan_reg, conv_data}),
		.rd_addr(rd_ptr_reg),
		.rd_data(mem_q)
	);

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	logic [31:0] rd_reg;
	logic fifo_rd_reg;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rd_reg <= '0;
			fifo_rd_reg <= 1'b0;
		end
		else
		begin
			rd_reg <= '0;
			fifo_rd_reg <= pop;
			if (rd)
			begin
				unique case (addr)
					adc_seq_pkg::sequencer_control_off:
					begin
						rd_reg[adc_seq_pkg::ctl_cont_bit] <= cont_reg;
						rd_reg[adc_seq_pkg::ctl_hw_bit] <= hw_mode_reg;
						rd_reg[adc_seq_pkg::ctl_slots_lsb +:
							adc_seq_pkg::slot_idx_w] <= last_slot_reg;
					end
					adc_seq_pkg::delay_off:
						rd_reg[adc_seq_pkg::delay_w-1:0] <= delay_reg;
					adc_seq_pkg::slot_channel_select_low_off,
					adc_seq_pkg::slot_channel_select_high_off:
					begin
						for (int i = 0; i < slot_n / 2; i++)
						begin
							rd_reg[i * adc_seq_pkg::slot_field_stride +:
								adc_seq_pkg::chan_w] <= slot_chan_reg[i +
								(addr[4] ? slot_n / 2 : 0)];
						end
					end
					adc_seq_pkg::analog_path_config_off:
					begin
						rd_reg[adc_seq_pkg::apc_route_lsb +:
							adc_seq_pkg::ext_inputs] <= route_reg;
						rd_reg[adc_seq_pkg::apc_inen_lsb +:
							adc_seq_pkg::ext_inputs] <= inen_reg;
						rd_reg[adc_seq_pkg::apc_path_bit] <= path_reg;
						rd_reg[adc_seq_pkg::apc_amp_bit] <= amp_reg;
						rd_reg[adc_seq_pkg::apc_div_lsb +:
							adc_seq_pkg::div_w] <= div_reg;
						rd_reg[adc_seq_pkg::apc_rail_bit] <= rail_reg;
					end
					adc_seq_pkg::status_off:
					begin
						rd_reg[cnt_w-1:0] <= count_reg;
						rd_reg[adc_seq_pkg::st_busy_bit] <= busy;
						rd_reg[adc_seq_pkg::st_thr_bit] <=
							fifo_threshold_irq;
						rd_reg[adc_seq_pkg::st_ovr_bit] <= ovr_reg;
					end
					adc_seq_pkg::threshold_off:
						rd_reg[cnt_w-1:0] <= thr_reg;
					default:
						rd_reg <= '0;
				endcase
			end
		end
	end

	// fifo word comes straight from the memory's output register
	assign rdata = fifo_rd_reg ? 32'(mem_q) : rd_reg;
endmodule : adc_sequencer_input_path
`default_nettype wire

// [verilog/result_fifo_mem.sv]
// small two-port memory holding converted results
// assumes one clock; read data come out of a register
`default_nettype none
module result_fifo_mem #(
	parameter int width = 17,
	parameter int depth = 16,
	parameter int addr_w = 4
) (
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [addr_w-1:0] wr_addr,
	input wire logic [width-1:0] wr_data,
	input wire logic [addr_w-1:0] rd_addr,
	output logic [width-1:0] rd_data
);
	logic [width-1:0] mem [depth];

	always_ff @(posedge clk)
	begin
		if (wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
	end

	// no reset on the array; pointers guard against stale reads
	always_ff @(posedge clk)
	begin
		rd_data <= mem[rd_addr];
	end
endmodule : result_fifo_mem
`default_nettype wire
